/* File: rtl/pbcs_regs.sv */
// Management register bank of the transceiver: basic control and status.
// Assumes the host runs the two-wire management bus at a fraction of core clock.
// Behaviour
// - Writing one to control bit 15 resets the device; bit self-clears, resets zero.
// - Writing one to bit 9 restarts negotiation; it self-clears.
// - Bit 13 picks 100 or 10 Mbps, ignored while negotiation enabled.
// - Negotiated result overrides speed and duplex bits; negotiation runs only enabled.
// - Speed bit reset value comes from the speed strap.
// - Negotiation enable reset value comes from its strap.
// - Bit 10 isolates the device from the media interface and line.
// - Isolate bit reset value comes from the isolate strap.
// - Bit 7 enables the collision test; resets zero.
// - Bit 0 turns the line transmitter off; resets zero.
// - Status bit 14 reads one and bit 15 reads zero.
// - Power-down via bit 11 keeps management reachable.
`timescale 1ns/1ps
`include "pbcs_consts.svh"
module pbcs_regs
    import pbcs_pkg::*;
#(
    parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value
    parameter logic [15:0] ID_LOW  = 16'h5670  // Arbitrary value
)
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // Management bus
    input  wire logic       mdc_in,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_out,
    input  wire logic [4:0] phy_addr_in,
    // Configuration straps
    input  wire logic       speed_strap_in,
    input  wire logic       negotiation_strap_pin_in,
    input  wire logic       isolate_strap_in,
    input  wire logic       duplex_strap_in,
    // Line and negotiation status
    input  wire logic       link_up_in,
    input  wire logic       an_complete_in,
    input  wire logic       remote_fault_in,
    input  wire logic       jabber_in,
    input  wire logic       an_speed_100_in,
    input  wire logic       an_full_duplex_in,
    // Control to the transceiver
    output logic            soft_reset_out,
    output logic            an_restart_out,
    output logic            an_enable_out,
    output logic            speed_100_out,
    output logic            full_duplex_out,
    output logic            loopback_out,
    output logic            power_down_out,
    output logic            isolate_out,
    output logic            col_test_out,
    output logic            tx_off_out
);
    logic [4:0]  reg_addr;
    logic [15:0] rd_data;
    logic        rd_pulse;
    logic        wr_pulse;
    logic [15:0] wr_data;
    logic        ctrl_wr;
    logic        stat_rd;
    logic        reload;
    logic        strap_load_ff;
    logic        soft_rst_ff;
    logic        restart_ff;
    logic        loopback_ff;
    logic        speed_ff;
    logic        an_en_ff;
    logic        power_down_ff;
    logic        isolate_ff;
    logic        duplex_ff;
    logic        col_test_ff;
    logic        tx_dis_ff;
    logic        link_lat_ff;
    logic        rf_lat_ff;
    logic        jab_lat_ff;
    logic [15:0] ctrl_word;
    logic [15:0] stat_word;

    // Frame engine; never gated by power-down so registers stay reachable
    // management stays alive
    pbcs_mdio_slave u_slave (
        .core_clk_in  (core_clk_in),
        .rst_b_in     (rst_b_in),
        .mdc_in       (mdc_in),
        .mdio_in      (mdio_in),
        .mdio_out     (mdio_out),
        .mdio_oe_out  (mdio_oe_out),
        .phy_addr_in  (phy_addr_in),
        .reg_addr_out (reg_addr),
        .rd_data_in   (rd_data),
        .rd_pulse_out (rd_pulse),
        .wr_pulse_out (wr_pulse),
        .wr_data_out  (wr_data)
    );

    // Access decode
    assign ctrl_wr = wr_pulse && (reg_addr == `PBCS_REG_BCTRL);
    assign stat_rd = rd_pulse && (reg_addr == `PBCS_REG_BSTAT);
    assign reload  = strap_load_ff || soft_rst_ff;

    // Straps are caught on the first edge after release, never in the reset arm
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strap_load_ff <= 1'b1;
        end else begin
            strap_load_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= ctrl_wr && wr_data[`PBCS_B_RST];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= ctrl_wr && !wr_data[`PBCS_B_RST] && wr_data[`PBCS_B_RSTAN];
        end
    end

    // Control bits; a write carrying soft reset drops its other bits,
    // since the reload that follows would overwrite them anyway
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            loopback_ff   <= 1'b0;
            speed_ff      <= 1'b0;
            an_en_ff      <= 1'b0;
            power_down_ff <= 1'b0;
            isolate_ff    <= 1'b0;
            duplex_ff     <= 1'b0;
            col_test_ff   <= 1'b0;
            tx_dis_ff     <= 1'b0;
        end else if (reload) begin
            loopback_ff   <= 1'b0;
            speed_ff      <= speed_strap_in;
            an_en_ff      <= negotiation_strap_pin_in;
            power_down_ff <= 1'b0;
            isolate_ff    <= isolate_strap_in;
            duplex_ff     <= ~duplex_strap_in;
            col_test_ff   <= 1'b0;
            tx_dis_ff     <= 1'b0;
        end else if (ctrl_wr && !wr_data[`PBCS_B_RST]) begin
            loopback_ff   <= wr_data[`PBCS_B_LOOP];
            speed_ff      <= wr_data[`PBCS_B_SPD];
            an_en_ff      <= wr_data[`PBCS_B_ANEN];
            power_down_ff <= wr_data[`PBCS_B_PD];
            isolate_ff    <= wr_data[`PBCS_B_ISO];
            duplex_ff     <= wr_data[`PBCS_B_DUP];
            col_test_ff   <= wr_data[`PBCS_B_COL];
            tx_dis_ff     <= wr_data[`PBCS_B_TXD];
        end
    end

    // Latched status; a new event in the read cycle beats the clear
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            link_lat_ff <= 1'b0;
            rf_lat_ff   <= 1'b0;
            jab_lat_ff  <= 1'b0;
        end else if (stat_rd) begin
            link_lat_ff <= link_up_in;
            rf_lat_ff   <= remote_fault_in;
            jab_lat_ff  <= jabber_in;
        end else begin
            link_lat_ff <= link_lat_ff && link_up_in;
            rf_lat_ff   <= rf_lat_ff || remote_fault_in;
            jab_lat_ff  <= jab_lat_ff || jabber_in;
        end
    end

    // Control word as read back; reserved bits read zero
    always_comb begin
        ctrl_word                  = 16'h0000;
        ctrl_word[`PBCS_B_RST]     = soft_rst_ff;
        ctrl_word[`PBCS_B_LOOP]    = loopback_ff;
        ctrl_word[`PBCS_B_SPD]     = speed_ff;
        ctrl_word[`PBCS_B_ANEN]    = an_en_ff;
        ctrl_word[`PBCS_B_PD]      = power_down_ff;
        ctrl_word[`PBCS_B_ISO]     = isolate_ff;
        ctrl_word[`PBCS_B_RSTAN]   = restart_ff;
        ctrl_word[`PBCS_B_DUP]     = duplex_ff;
        ctrl_word[`PBCS_B_COL]     = col_test_ff;
        ctrl_word[`PBCS_B_TXD]     = tx_dis_ff;
    end

    always_comb begin
        stat_word                = `PBCS_STAT_CAP;
        stat_word[`PBCS_S_ANC]   = an_complete_in;
        stat_word[`PBCS_S_RF]    = rf_lat_ff;
        stat_word[`PBCS_S_LINK]  = link_lat_ff;
        stat_word[`PBCS_S_JAB]   = jab_lat_ff;
    end

    // Read mux; registers without modelled fields read zero
    always_comb begin
        unique case (reg_addr)
            `PBCS_REG_BCTRL: rd_data = ctrl_word;
            `PBCS_REG_BSTAT: rd_data = stat_word;
            `PBCS_REG_IDH:   rd_data = ID_HIGH;
            `PBCS_REG_IDL:   rd_data = ID_LOW;
            default:         rd_data = 16'h0000;
        endcase
    end

    // Effective operating mode; negotiation result wins when enabled
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            speed_100_out   <= 1'b0;
            full_duplex_out <= 1'b0;
            an_enable_out   <= 1'b0;
        end else begin
            speed_100_out   <= an_en_ff ? an_speed_100_in : speed_ff;
            full_duplex_out <= an_en_ff ? an_full_duplex_in : duplex_ff;
            an_enable_out   <= an_en_ff;
        end
    end

    // Mode outputs; isolation and power-down also silence the transmitter
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            loopback_out   <= 1'b0;
            power_down_out <= 1'b0;
            isolate_out    <= 1'b0;
            col_test_out   <= 1'b0;
            tx_off_out     <= 1'b0;
        end else begin
            loopback_out   <= loopback_ff;
            power_down_out <= power_down_ff;
            isolate_out    <= isolate_ff;
            col_test_out   <= col_test_ff;
            tx_off_out     <= tx_dis_ff || power_down_ff || isolate_ff;
        end
    end

    // Pulses straight from their flops
    assign soft_reset_out = soft_rst_ff;
    assign an_restart_out = restart_ff;

    // Soft reset lasts one cycle then clears
    property p_rst_sc;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        ctrl_wr && wr_data[`PBCS_B_RST] |=> soft_rst_ff ##1 !soft_rst_ff;
    endproperty
    a_rst_sc: assert property (p_rst_sc) else $error("soft reset not self-clearing");

    // Restart pulses once
    property p_restart;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        ctrl_wr && !wr_data[`PBCS_B_RST] && wr_data[`PBCS_B_RSTAN]
        |=> an_restart_out ##1 !an_restart_out;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");

    // Manual speed ignored under negotiation
    property p_speed_ign;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        an_en_ff |=> speed_100_out == $past(an_speed_100_in);
    endproperty
    a_speed_ign: assert property (p_speed_ign) else $error("manual speed used");

    // Manual settings apply only without negotiation
    property p_manual;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !an_en_ff |=> full_duplex_out == $past(duplex_ff) && !an_enable_out
                      && speed_100_out == $past(speed_ff);
    endproperty
    a_manual: assert property (p_manual) else $error("manual mode wrong");

    // Speed strap reloaded at soft reset
    property p_strap_spd;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        soft_rst_ff |=> speed_ff == $past(speed_strap_in);
    endproperty
    a_strap_spd: assert property (p_strap_spd) else $error("speed strap lost");

    // Negotiation strap reloaded at soft reset
    property p_strap_an;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        soft_rst_ff |=> an_en_ff == $past(negotiation_strap_pin_in);
    endproperty
    a_strap_an: assert property (p_strap_an) else $error("negotiation strap lost");

    // Isolation reaches both outputs
    property p_iso;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        isolate_ff |=> isolate_out && tx_off_out;
    endproperty
    a_iso: assert property (p_iso) else $error("isolation not applied");

    // Isolate strap reloaded at soft reset
    property p_strap_iso;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        soft_rst_ff |=> isolate_ff == $past(isolate_strap_in);
    endproperty
    a_strap_iso: assert property (p_strap_iso) else $error("isolate strap lost");

    // Collision test follows the written bit
    property p_col;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        ctrl_wr && !wr_data[`PBCS_B_RST] |=> col_test_ff == $past(wr_data[`PBCS_B_COL])
                                          ##1 col_test_out == $past(col_test_ff);
    endproperty
    a_col: assert property (p_col) else $error("collision test bit wrong");

    // Transmitter off whenever the disable bit is set
    property p_txd;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        tx_dis_ff |=> tx_off_out;
    endproperty
    a_txd: assert property (p_txd) else $error("transmitter not off");

    // Capability bits on a status read
    property p_cap;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        reg_addr == `PBCS_REG_BSTAT |-> rd_data[15:14] == 2'h1;
    endproperty
    a_cap: assert property (p_cap) else $error("capability bits wrong");

    // Power-down can be left by a write
    property p_pd;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        power_down_ff && ctrl_wr && !wr_data[`PBCS_B_RST] && !wr_data[`PBCS_B_PD]
        |=> !power_down_ff ##1 !power_down_out;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down not left");

    // Duplex reload is the inverse strap
    property p_dup;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        soft_rst_ff |=> duplex_ff == !$past(duplex_strap_in);
    endproperty
    a_dup: assert property (p_dup) else $error("duplex strap wrong");
endmodule

/* File: rtl/pbcs_consts.svh */
// Constants of the management register bank: offsets, bit positions, values.
// Assumes a 5-bit register address as carried by the serial management frame.
`ifndef PBCS_CONSTS_SVH
`define PBCS_CONSTS_SVH
// Register offsets
`define PBCS_REG_BCTRL   5'h00
`define PBCS_REG_BSTAT   5'h01
`define PBCS_REG_IDH     5'h02
`define PBCS_REG_IDL     5'h03
`define PBCS_REG_ADV     5'h04
`define PBCS_REG_PABL    5'h05
`define PBCS_REG_EXPN    5'h06
`define PBCS_REG_NPG     5'h07
`define PBCS_REG_PNPG    5'h08
`define PBCS_REG_MIICTL  5'h14
`define PBCS_REG_RXERC   5'h15
`define PBCS_REG_IRQCS   5'h1b
`define PBCS_REG_VCTL1   5'h1e
`define PBCS_REG_VCTL2   5'h1f
// Basic control bit positions
`define PBCS_B_RST       15
`define PBCS_B_LOOP      14
`define PBCS_B_SPD       13
`define PBCS_B_ANEN      12
`define PBCS_B_PD        11
`define PBCS_B_ISO       10
`define PBCS_B_RSTAN     9
`define PBCS_B_DUP       8
`define PBCS_B_COL       7
`define PBCS_B_TXD       0
// Basic status fixed capability bits and live bit positions
`define PBCS_STAT_CAP    16'h7849
`define PBCS_S_ANC       5
`define PBCS_S_RF        4
`define PBCS_S_LINK      2
`define PBCS_S_JAB       1
// Frame fields
`define PBCS_OP_RD       2'h2
`define PBCS_OP_WR       2'h1
`define PBCS_HDR_LAST    4'hc
`define PBCS_DATA_LAST   4'hf
`endif

/* File: rtl/pbcs_pkg.sv */
// Types shared by the management register bank modules.
// Assumes the constants header is included by each user.
package pbcs_pkg;
    typedef enum logic [1:0] {
        ms_idle,
        ms_hdr,
        ms_ta,
        ms_data
    } pbcs_mstate_type;
endpackage

/* File: rtl/pbcs_mdio_slave.sv */
// Serial management frame engine: decodes read and write frames.
// Assumes mdc and mdio are synchronous to the core clock and far slower.
`timescale 1ns/1ps
`include "pbcs_consts.svh"
module pbcs_mdio_slave
    import pbcs_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    // Serial pins
    input  wire logic        mdc_in,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_out,
    input  wire logic [4:0]  phy_addr_in,
    // Register side
    output logic [4:0]       reg_addr_out,
    input  wire logic [15:0] rd_data_in,
    output logic             rd_pulse_out,
    output logic             wr_pulse_out,
    output logic [15:0]      wr_data_out
);
    pbcs_mstate_type state_ff;
    logic            mdc_q_ff;
    logic [3:0]      cnt_ff;
    logic [15:0]     sh_ff;
    logic            mine_ff;
    logic            is_rd_ff;
    logic            mdc_rise;
    logic [12:0]     hdr;

    assign mdc_rise = mdc_in & ~mdc_q_ff;
    assign hdr = {sh_ff[11:0], mdio_in};

    // Previous clock level for edge finding
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mdc_q_ff <= 1'b0;
        end else begin
            mdc_q_ff <= mdc_in;
        end
    end

    // Frame sequencer; preamble is optional since suppression is supported
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff     <= ms_idle;
            cnt_ff       <= 4'h0;
            sh_ff        <= 16'h0000;
            mine_ff      <= 1'b0;
            is_rd_ff     <= 1'b0;
            reg_addr_out <= 5'h00;
            mdio_out     <= 1'b0;
            mdio_oe_out  <= 1'b0;
            rd_pulse_out <= 1'b0;
            wr_pulse_out <= 1'b0;
            wr_data_out  <= 16'h0000;
        end else begin
            rd_pulse_out <= 1'b0;
            wr_pulse_out <= 1'b0;
            if (mdc_rise) begin
                unique case (state_ff)
                    ms_idle: begin
                        if (!mdio_in) begin
                            state_ff <= ms_hdr;
                            cnt_ff   <= 4'h0;
                        end
                    end
                    ms_hdr: begin
                        sh_ff  <= {sh_ff[14:0], mdio_in};
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == `PBCS_HDR_LAST) begin
                            // Foreign frames are still walked so data bits cause no false start
                            mine_ff      <= hdr[12] && (hdr[9:5] == phy_addr_in) &&
                                            (hdr[11:10] == `PBCS_OP_RD ||
                                             hdr[11:10] == `PBCS_OP_WR);
                            is_rd_ff     <= (hdr[11:10] == `PBCS_OP_RD);
                            reg_addr_out <= hdr[4:0];
                            state_ff     <= ms_ta;
                            cnt_ff       <= 4'h0;
                        end
                    end
                    ms_ta: begin
                        cnt_ff <= 4'h1;
                        if (cnt_ff == 4'h0) begin
                            mdio_oe_out <= mine_ff && is_rd_ff;
                            mdio_out    <= 1'b0;
                        end else begin
                            state_ff     <= ms_data;
                            cnt_ff       <= 4'h0;
                            sh_ff        <= rd_data_in;
                            mdio_out     <= rd_data_in[15];
                            rd_pulse_out <= mine_ff && is_rd_ff;
                        end
                    end
                    ms_data: begin
                        cnt_ff <= cnt_ff + 4'h1;
                        if (is_rd_ff) begin
                            sh_ff    <= {sh_ff[14:0], 1'b0};
                            mdio_out <= sh_ff[14];
                        end else begin
                            sh_ff <= {sh_ff[14:0], mdio_in};
                        end
                        if (cnt_ff == `PBCS_DATA_LAST) begin
                            state_ff     <= ms_idle;
                            mdio_oe_out  <= 1'b0;
                            mdio_out     <= 1'b0;
                            wr_pulse_out <= mine_ff && !is_rd_ff;
                            wr_data_out  <= {sh_ff[14:0], mdio_in};
                        end
                    end
                endcase
            end
        end
    end
endmodule

/* File: verif/pbcs_host_model.sv */
// Station management host model: sends read and write frames.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module pbcs_host_model (
    // Clock and shared wire
    input  wire logic clk_in,
    input  wire logic mdio_in,
    // Host drive
    output logic      mdc_out,
    output logic      mdio_out,
    output logic      mdio_oe_out
);
    // Idle: clock parked low, data released
    initial begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_out = 1'b0;
    end

    // One frame of 32 bits, 8 core clocks per bit; released for read turnaround
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] bits;
        bits = {2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk_in) #1;
            mdc_out = 1'b0;
            mdio_oe_out = !(op == 2'b10 && i < 18);
            mdio_out = bits[i];
            repeat (4) @(posedge clk_in);
            #1 mdc_out = 1'b1;
            if (i < 16) rd[i] = mdio_in; // Data sampled at the rise
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in) #1;
        mdc_out = 1'b0;
        mdio_oe_out = 1'b0;
    endtask
endmodule

/* File: verif/test_pbcs_regs.sv */
// Bench of the management register bank, driven through the host model.
// Assumes phy address 5'h03 and a pulled-up data wire.
`timescale 1ns/1ps
module test_pbcs_regs;
    logic        clk, rst_b, mdio_w, d_out, d_oe, mdc, h_out, h_oe;
    logic        spd_s, neg_s, iso_s, dup_s, anc, an100, anfd;
    logic        srst, arst, an_en, s100, fd, loop, pd, iso, col, txoff;
    logic [15:0] d;
    int          miscompares, total_checks, sr_cnt, ar_cnt, cyc;

    // Released wire floats to the pull-up level
    assign mdio_w = d_oe ? d_out : (h_oe ? h_out : 1'b1);

    pbcs_regs pbcs_regs_i (.core_clk_in(clk), .rst_b_in(rst_b), .mdc_in(mdc),
        .mdio_in(mdio_w), .mdio_out(d_out), .mdio_oe_out(d_oe), .phy_addr_in(5'h03),
        .speed_strap_in(spd_s), .negotiation_strap_pin_in(neg_s), .isolate_strap_in(iso_s),
        .duplex_strap_in(dup_s), .link_up_in(1'b0), .an_complete_in(anc),
        .remote_fault_in(1'b0), .jabber_in(1'b0), .an_speed_100_in(an100),
        .an_full_duplex_in(anfd), .soft_reset_out(srst), .an_restart_out(arst),
        .an_enable_out(an_en), .speed_100_out(s100), .full_duplex_out(fd),
        .loopback_out(loop), .power_down_out(pd), .isolate_out(iso),
        .col_test_out(col), .tx_off_out(txoff));

    pbcs_host_model pbcs_host_model_i (.clk_in(clk), .mdio_in(mdio_w), .mdc_out(mdc),
        .mdio_out(h_out), .mdio_oe_out(h_oe));

    // Clock at 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Pulse counters and hang guard; the ceiling is well above the frame count
    always @(posedge clk) begin
        cyc++;
        if (srst === 1'b1) sr_cnt++;
        if (arst === 1'b1) ar_cnt++;
        if (cyc == 10000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] x;
        pbcs_host_model_i.frame(2'b01, 5'h03, ra, wd, x);
        repeat (4) @(posedge clk);
        #1; // Hand back off the edge so the next stimulus keeps the same skew
    endtask

    task automatic rd(input logic [4:0] ra, output logic [15:0] r);
        pbcs_host_model_i.frame(2'b10, 5'h03, ra, 16'h0000, r);
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Strap-loaded reset values: speed 1, negotiation 0, isolate 1, duplex inverted
    task automatic t_reset();
        rd(5'h00, d);
        chk(d, 16'h2500);
        chk({11'h0, an_en, s100, fd, iso, txoff}, 16'h000f);
        $display("t_reset done");
    endtask

    // Fixed capability bits, live completion bit, foreign address left alone
    task automatic t_status();
        anc = 1'b1;
        rd(5'h01, d);
        chk(d & 16'hc020, 16'h4020);
        pbcs_host_model_i.frame(2'b10, 5'h1c, 5'h01, 16'h0000, d);
        chk(d, 16'hffff);
        $display("t_status done");
    endtask

    // Reserved bits stay zero; registers still answer while powered down
    task automatic t_write();
        wr(5'h00, 16'h48ff);
        chk({11'h0, loop, pd, col, txoff, iso}, 16'h001e);
        rd(5'h00, d);
        chk(d, 16'h4881);
        $display("t_write done");
    endtask

    // Manual speed versus negotiated result
    task automatic t_mode();
        an100 = 1'b0;
        anfd = 1'b1;
        wr(5'h00, 16'h2000);
        chk({13'h0, s100, fd, an_en}, 16'h0004);
        wr(5'h00, 16'h3000);
        chk({13'h0, s100, fd, an_en}, 16'h0003);
        $display("t_mode done");
    endtask

    // Restart is a single pulse and reads back cleared
    task automatic t_restart();
        ar_cnt = 0;
        wr(5'h00, 16'h1200);
        chk(16'(ar_cnt), 16'h0001);
        rd(5'h00, d);
        chk(d, 16'h1000);
        $display("t_restart done");
    endtask

    // Isolate on then off; the disable bit alone must still silence the line
    task automatic t_iso();
        wr(5'h00, 16'h0400);
        chk({14'h0, iso, txoff}, 16'h0003);
        wr(5'h00, 16'h0001);
        chk({14'h0, iso, txoff}, 16'h0001);
        $display("t_iso done");
    endtask

    // Soft reset pulses once, self-clears and reloads the straps;
    // negotiation strap flipped so its reload differs from the cleared bit
    task automatic t_soft();
        neg_s = 1'b1;
        wr(5'h00, 16'h4881);
        sr_cnt = 0;
        wr(5'h00, 16'h8000);
        chk(16'(sr_cnt), 16'h0001);
        rd(5'h00, d);
        chk(d, 16'h3500);
        $display("t_soft done");
    endtask

    // Main sequence: straps set before reset is released
    initial begin
        {spd_s, neg_s, iso_s, dup_s} = 4'b1010;
        {anc, an100, anfd} = 3'b000;
        rst_b = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_status();
        t_write();
        t_mode();
        t_restart();
        t_iso();
        t_soft();
        final_report();
    end
endmodule
